// ---- inc/sac_pkg.sv ----
// Purpose: Shared constants and types for the successive-approximation converter control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Printed offsets not all multiples of four, so they are word indices
package sac_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS   = 8'h0c;
	localparam logic [7:0] IDX_CONTROL = 8'h1f;
	localparam logic [7:0] IDX_ENABLES = 8'h8c;
	localparam logic [7:0] IDX_RESULT  = 8'h1e;
	localparam logic [7:0] IDX_PORTCFG = 8'h9f;
	localparam logic [7:0] IDX_SLEEP   = 8'h40;

	// Control register field positions and done flag bit of the flag and enable registers
	localparam int CLK_SEL_HI  = 7;
	localparam int CLK_SEL_LO  = 6;
	localparam int CHAN_HI     = 5;
	localparam int CHAN_LO     = 3;
	localparam int GO_BIT      = 2;
	localparam int ON_BIT      = 0;
	localparam int DONE_FLAG   = 6;

	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST   = 8'h00;
	localparam logic [7:0] ENABLES_RST = 8'h00;
	localparam logic [7:0] PORTCFG_RST = 8'h00;
	localparam logic [7:0] RESULT_RST  = 8'h00;

	// Channel counts of the two variants
	localparam logic [3:0] CHANS_SMALL = 4'h5;
	localparam logic [3:0] CHANS_LARGE = 4'h8;

	// Conversion clock divisors in core cycles
	localparam logic [5:0] DIV_OSC2  = 6'h02;
	localparam logic [5:0] DIV_OSC8  = 6'h08;
	localparam logic [5:0] DIV_OSC32 = 6'h20;
	localparam logic [1:0] SEL_RC    = 2'h3;

	// Nine and a half periods: counted in half periods
	localparam logic [4:0] HALF_PERIODS = 5'h13;
	localparam logic [4:0] HALF_SAMPLE  = 5'h03;

	typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_state_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} sac_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} sac_apb_rsp_t;
endpackage

// ---- rtl/sac_tick.sv ----
// Purpose: Half-period tick of the selected conversion clock
// Assumes: rc_tick is a one-cycle pulse from the internal oscillator
// Notes:   Emits one pulse per half bit-conversion period
`timescale 1ns/1ns
module sac_tick (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] clk_sel,
	input  wire logic       rc_tick,
	// Output
	output      logic       half_tick
);
	typedef struct packed {
		logic [5:0] count;
		logic       tick;
	} sac_tick_st_t;

	sac_tick_st_t st;
	sac_tick_st_t next_st;
	logic [5:0]   half_div;

	always_comb begin
		next_st = st;
		case (clk_sel)
			2'h0: half_div = sac_pkg::DIV_OSC2 >> 1;
			2'h1: half_div = sac_pkg::DIV_OSC8 >> 1;
			2'h2: half_div = sac_pkg::DIV_OSC32 >> 1;
			default: half_div = 6'h01;
		endcase
		next_st.tick = 1'b0;
		if (!run) begin
			next_st.count = 6'h00;
		end else if (clk_sel == sac_pkg::SEL_RC) begin
			next_st.tick = rc_tick; // see (RULE6)
		end else if (st.count + 6'h01 >= half_div) begin
			next_st.count = 6'h00;
			next_st.tick = 1'b1; // see (RULE5)
		end else begin
			next_st.count = st.count + 6'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign half_tick = st.tick;
endmodule

// ---- rtl/sac_sar.sv ----
// Purpose: Successive-approximation bit register
// Assumes: comp_hi is high when the held sample is above the trial level
// Notes:   One bit resolved per step, most significant first
`timescale 1ns/1ns
module sac_sar (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Control
	input  wire logic       clear,
	input  wire logic       step,
	input  wire logic       comp_hi,
	// Trial word
	output      logic [7:0] trial
);
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] mask;
	} sac_sar_st_t;

	sac_sar_st_t st;
	sac_sar_st_t next_st;

	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.code = 8'h80;
			next_st.mask = 8'h80;
		end else if (step && st.mask != 8'h00) begin
			next_st.code = comp_hi ? st.code : (st.code & ~st.mask); // see (RULE2)
			next_st.mask = st.mask >> 1;
			next_st.code = next_st.code | next_st.mask;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign trial = st.code;
endmodule

// ---- rtl/sac_adc_ctrl.sv ----
// Purpose: Converter control with APB register file, sleep handling and interrupt
// Assumes: APB slave, zero-wait answers, analog comparator outside
// Notes:   Registers sit at four times their printed index
`timescale 1ns/1ns
// Summary of operation
// (RULE1) Sampled input becomes an unsigned 8-bit result word.
// (RULE2) Result found by successive approximation, one bit per step.
// (RULE3) Software picks supply or external reference pin as reference.
// (RULE4) Conversion continues in sleep only with the internal RC clock.
// (RULE5) Clock select 00, 01, 10 give oscillator over 2, 8, 32.
// (RULE6) Clock select 11 picks internal RC oscillator, usable in sleep.
// (RULE7) Channel field value n routes analog channel n to sample-and-hold.
// (RULE8) Writing go bit starts conversion; hardware clears it on finish.
// (RULE9) Clearing go mid-conversion aborts; result register stays unchanged.
// (RULE10) Each conversion lasts nine and a half bit periods.
// (RULE11) Completion in sleep with interrupt enabled raises wake-up.
// (RULE12) Port config register sets pins analog or digital, reference pin option.
// (RULE13) Small variant five channels, large eight; 5 to 7 large only.
// (RULE14) Software keeps done flag and enable clear on converterless parts.
// (RULE15) Control register at index 1Fh, resets zero, bit 1 reads zero.
// (RULE16) Converter off: engine idle, no current, start requests ignored.
module sac_adc_ctrl #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// APB
	input  wire sac_pkg::sac_apb_req_t apb_req,
	output      sac_pkg::sac_apb_rsp_t apb_rsp,
	// Processor and analog side
	input  wire logic                 cpu_sleep,
	input  wire logic                 rc_tick,
	input  wire logic                 comp_hi,
	output      logic [2:0]           chan_sel,
	output      logic                 ref_ext,
	output      logic [7:0]           analog_pins,
	output      logic [7:0]           dac_code,
	output      logic                 sample_en,
	output      logic                 analog_power,
	// Events
	output      logic                 irq,
	output      logic                 wake
);
	typedef struct packed {
		sac_pkg::sac_apb_rsp_t rsp;
		logic [7:0]            control;
		logic [7:0]            flags;
		logic [7:0]            enables;
		logic [7:0]            result;
		logic [7:0]            portcfg;
		sac_pkg::sac_state_t   state;
		logic [4:0]            halves;
		logic                  irq;
		logic                  wake;
		logic [2:0]            chan;
		logic                  ref_ext;
		logic [7:0]            pins;
		logic                  sample;
		logic                  power;
		logic [7:0]            dac;
	} sac_st_t;

	sac_st_t    st;
	sac_st_t    next_st;
	logic       half_tick;
	logic [7:0] trial;
	logic       run;
	logic       sar_clear;
	logic       sar_step;
	logic       access;
	logic       setup;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       hit;
	logic       rc_sel;
	logic       go_new;
	logic       finish;
	logic       abort;
	logic [3:0] nchan;

	assign run = (st.state != sac_pkg::SAC_IDLE);
	assign rc_sel = (st.control[sac_pkg::CLK_SEL_HI:sac_pkg::CLK_SEL_LO] == sac_pkg::SEL_RC);

	sac_tick u_tick (
		.core_clk  (core_clk),
		.reset     (reset),
		.run       (run),
		.clk_sel   (st.control[sac_pkg::CLK_SEL_HI:sac_pkg::CLK_SEL_LO]),
		.rc_tick   (rc_tick),
		.half_tick (half_tick)
	);

	sac_sar u_sar (
		.core_clk (core_clk),
		.reset    (reset),
		.clear    (sar_clear),
		.step     (sar_step),
		.comp_hi  (comp_hi),
		.trial    (trial)
	);

	always_comb begin
		next_st = st;
		access = apb_req.psel && apb_req.penable;
		setup = apb_req.psel && !apb_req.penable;
		wr = access && apb_req.pwrite;
		rd = access && !apb_req.pwrite;
		idx = apb_req.paddr[9:2];
		wdata = apb_req.pwdata[7:0];
		nchan = LARGE_VARIANT ? sac_pkg::CHANS_LARGE : sac_pkg::CHANS_SMALL; // see (RULE13)
		hit = 1'b1;
		rdata = 8'h00;
		sar_clear = 1'b0;
		sar_step = 1'b0;
		go_new = 1'b0;
		finish = 1'b0;
		abort = 1'b0;

		// Address decode
		if (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[31:10] != 22'h0) begin
			hit = 1'b0;
		end else if (idx == sac_pkg::IDX_FLAGS) begin
			rdata = st.flags;
		end else if (idx == sac_pkg::IDX_CONTROL) begin
			rdata = st.control & 8'hfd; // see (RULE15)
		end else if (idx == sac_pkg::IDX_ENABLES) begin
			rdata = st.enables;
		end else if (idx == sac_pkg::IDX_RESULT) begin
			rdata = st.result;
		end else if (idx == sac_pkg::IDX_PORTCFG) begin
			rdata = st.portcfg;
		end else begin
			hit = 1'b0;
		end

		// Answer loaded in the setup cycle so it stands through the access phase
		next_st.rsp.pready = 1'b1;
		if (setup) begin
			next_st.rsp.prdata = {24'h000000, rdata};
			next_st.rsp.pslverr = !hit;
		end else if (!access) begin
			next_st.rsp.pslverr = 1'b0;
		end

		// Register writes
		if (wr && hit) begin
			if (idx == sac_pkg::IDX_CONTROL) begin
				next_st.control = wdata & 8'hfd; // see (RULE15)
				go_new = wdata[sac_pkg::GO_BIT] && !st.control[sac_pkg::GO_BIT];
				if (!wdata[sac_pkg::ON_BIT]) begin
					next_st.control[sac_pkg::GO_BIT] = 1'b0; // see (RULE16)
				end
			end else if (idx == sac_pkg::IDX_ENABLES) begin
				next_st.enables = wdata;
			end else if (idx == sac_pkg::IDX_RESULT) begin
				next_st.result = wdata;
			end else if (idx == sac_pkg::IDX_PORTCFG) begin
				next_st.portcfg = wdata; // see (RULE12)
			end
		end

		// Read of the flag register clears only the bits it reported
		if (rd && hit && idx == sac_pkg::IDX_FLAGS) begin
			next_st.flags = st.flags & ~st.rsp.prdata[7:0];
		end

		// Conversion engine
		abort = run && (!next_st.control[sac_pkg::GO_BIT] || (cpu_sleep && !rc_sel)); // see (RULE9)
		if (abort && cpu_sleep && !rc_sel) begin
			next_st.control[sac_pkg::GO_BIT] = 1'b0; // see (RULE4)
		end
		case (st.state)
			sac_pkg::SAC_IDLE: begin
				if (go_new && st.control[sac_pkg::ON_BIT] && next_st.control[sac_pkg::ON_BIT]) begin
					next_st.state = sac_pkg::SAC_SAMPLE; // see (RULE8)
					next_st.halves = 5'h00;
					sar_clear = 1'b1;
				end else if (go_new) begin
					next_st.control[sac_pkg::GO_BIT] = 1'b0; // see (RULE16)
				end
			end
			sac_pkg::SAC_SAMPLE: begin
				if (abort) begin
					next_st.state = sac_pkg::SAC_IDLE;
				end else if (half_tick) begin
					next_st.halves = st.halves + 5'h01;
					if (st.halves + 5'h01 == sac_pkg::HALF_SAMPLE) begin
						next_st.state = sac_pkg::SAC_CONVERT;
					end
				end
			end
			sac_pkg::SAC_CONVERT: begin
				if (abort) begin
					next_st.state = sac_pkg::SAC_IDLE; // see (RULE9)
				end else if (half_tick) begin
					next_st.halves = st.halves + 5'h01;
					sar_step = st.halves[0]; // see (RULE2)
					if (st.halves + 5'h01 == sac_pkg::HALF_PERIODS) begin // see (RULE10)
						finish = 1'b1;
					end
				end
			end
			default: next_st.state = sac_pkg::SAC_IDLE;
		endcase

		if (finish) begin
			next_st.state = sac_pkg::SAC_IDLE;
			next_st.result = trial; // see (RULE1)
			next_st.control[sac_pkg::GO_BIT] = 1'b0; // see (RULE8)
			next_st.flags[sac_pkg::DONE_FLAG] = 1'b1; // set wins over read clear
			next_st.wake = cpu_sleep && st.enables[sac_pkg::DONE_FLAG]; // see (RULE11)
		end
		if (!cpu_sleep) begin
			next_st.wake = 1'b0;
		end

		next_st.irq = |(next_st.flags & next_st.enables);
		next_st.chan = next_st.control[sac_pkg::CHAN_HI:sac_pkg::CHAN_LO]; // see (RULE7)
		if ({1'b0, next_st.chan} >= nchan) begin
			next_st.chan = 3'h0; // see (RULE13)
		end
		next_st.ref_ext = next_st.portcfg[0]; // see (RULE3)
		next_st.pins = ~next_st.portcfg;
		if (!LARGE_VARIANT) begin
			next_st.pins[7:5] = 3'h0;
		end
		// Sleep without RC clock, or engine idle while asleep (with or without wake): module off
		next_st.power = next_st.control[sac_pkg::ON_BIT]
			&& !(cpu_sleep && (!rc_sel || next_st.state == sac_pkg::SAC_IDLE)); // see (RULE4)
		// Sample switch only closes while powered
		next_st.sample = (next_st.state != sac_pkg::SAC_CONVERT) && next_st.power; // see (RULE16)
		next_st.dac = sar_clear ? 8'h80 : trial;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st <= '0;
			st.control <= sac_pkg::CONTROL_RST;
			st.flags <= sac_pkg::FLAGS_RST;
			st.enables <= sac_pkg::ENABLES_RST;
			st.result <= sac_pkg::RESULT_RST;
			st.portcfg <= sac_pkg::PORTCFG_RST;
			st.state <= sac_pkg::SAC_IDLE;
			st.pins <= 8'hff;
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp = st.rsp;
	assign irq = st.irq;
	assign wake = st.wake;
	assign chan_sel = st.chan;
	assign ref_ext = st.ref_ext;
	assign analog_pins = st.pins;
	assign dac_code = st.dac;
	assign sample_en = st.sample;
	assign analog_power = st.power;
endmodule

// ---- sim/sac_afe.sv ----
// Purpose: Analog multiplexer, sample-and-hold and comparator model
// Assumes: Channel n carries a fixed level 13h plus 1Dh times n
// Notes:   Hold follows the channel while the switch is closed
`timescale 1ns/1ns
module sac_afe (
	// Clock
	input  wire logic       core_clk,
	// Converter side
	input  wire logic [2:0] chan_sel,
	input  wire logic       sample_en,
	input  wire logic [7:0] dac_code,
	// Comparator
	output      logic       comp_hi
);
	logic [7:0] held = 8'h00;

	always @(posedge core_clk) begin
		if (sample_en) begin
			held <= 8'h13 + 8'h1d * {5'h00, chan_sel};
		end
	end
	assign comp_hi = held > dac_code;
endmodule

// ---- sim/sac_sva.sv ----
// Purpose: Port assertions for the converter control
// Assumes: Bound to the sac_adc_ctrl converter control module
// Notes:   Register contents seen only through APB
`timescale 1ns/1ns
module sac_sva (
	input wire logic                  core_clk,
	input wire logic                  reset,
	input wire sac_pkg::sac_apb_req_t apb_req,
	input wire sac_pkg::sac_apb_rsp_t apb_rsp,
	input wire logic                  cpu_sleep,
	input wire logic [2:0]            chan_sel,
	input wire logic                  ref_ext,
	input wire logic [7:0]            analog_pins,
	input wire logic                  sample_en,
	input wire logic                  analog_power,
	input wire logic                  wake
);
	logic mapped;

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	assign mapped = apb_req.paddr inside {32'h30, 32'h7c, 32'h230, 32'h78, 32'h27c};
	sequence s_acc(a, w);
		apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.paddr == a
			&& apb_req.pwrite == w;
	endsequence

	pready_on_a: assert property (!$past(reset) |-> apb_rsp.pready) else $error("pready low");
	refused_a: assert property (apb_req.psel && apb_req.penable && !mapped |-> apb_rsp.pslverr)
		else $error("no error on unmapped");
	mapped_ok_a: assert property (apb_req.psel && apb_req.penable && mapped |-> !apb_rsp.pslverr)
		else $error("error on mapped");
	ctrl_read_a: assert property (s_acc(32'h7c, 0) |-> apb_rsp.prdata[31:8] == 24'h0
		&& !apb_rsp.prdata[1]) else $error("control read bits");
	ref_cfg_a: assert property (s_acc(32'h27c, 1) |=> ref_ext == $past(apb_req.pwdata[0])
		&& analog_pins == ~$past(apb_req.pwdata[7:0])) else $error("port config");
	chan_route_a: assert property (s_acc(32'h7c, 1) ##0 (apb_req.pwdata[5:3] == 3'h6)
		|=> ##[0:1] chan_sel == 3'h6) else $error("channel");
	off_idle_a: assert property (!analog_power |-> !sample_en) else $error("idle sample");
	power_on_a: assert property (s_acc(32'h7c, 1) ##0 (apb_req.pwdata[0] && !cpu_sleep)
		|=> ##[0:1] analog_power) else $error("power on");
	power_off_a: assert property (s_acc(32'h7c, 1) ##0 !apb_req.pwdata[0]
		|=> ##[0:1] !analog_power) else $error("power off");
	wake_drop_a: assert property (wake && !cpu_sleep |=> !wake) else $error("wake");
endmodule
bind sac_adc_ctrl sac_sva i_sac_sva (.core_clk(core_clk), .reset(reset), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .cpu_sleep(cpu_sleep), .chan_sel(chan_sel), .ref_ext(ref_ext),
	.analog_pins(analog_pins), .sample_en(sample_en), .analog_power(analog_power), .wake(wake));

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the converter control
// Assumes: APB read data and error taken at the completing edge
// Notes:   RC oscillator pulses every fifth cycle
`timescale 1ns/1ns
module tb_top;
	logic                  core_clk  = 1'b0;
	logic                  reset     = 1'b1;
	logic                  cpu_sleep = 1'b0;
	logic                  rc_tick   = 1'b0;
	sac_pkg::sac_apb_req_t req       = '0;
	sac_pkg::sac_apb_rsp_t rsp;
	logic                  comp_hi, ref_ext, sample_en, analog_power, irq, wake, err;
	logic [2:0]            chan_sel;
	logic [7:0]            analog_pins, dac_code, rd_v;
	int                    errors = 0;
	int                    checks = 0;
	int                    n      = 0;

	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		n <= n + 1;
		rc_tick <= (n % 5 == 0);
	end
	sac_adc_ctrl #(.LARGE_VARIANT(1'b1)) i_sac_adc_ctrl (.core_clk(core_clk), .reset(reset),
		.apb_req(req), .apb_rsp(rsp), .cpu_sleep(cpu_sleep), .rc_tick(rc_tick),
		.comp_hi(comp_hi), .chan_sel(chan_sel), .ref_ext(ref_ext), .analog_pins(analog_pins),
		.dac_code(dac_code), .sample_en(sample_en), .analog_power(analog_power), .irq(irq),
		.wake(wake));
	sac_afe i_sac_afe (.core_clk(core_clk), .chan_sel(chan_sel), .sample_en(sample_en),
		.dac_code(dac_code), .comp_hi(comp_hi));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
		@(posedge core_clk);
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= {24'h0, d};
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge core_clk);
		req.penable <= 1'b1;
		@(posedge core_clk);
		while (rsp.pready !== 1'b1) @(posedge core_clk);
		rd_v = rsp.prdata[7:0];
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic logic [7:0] sar(input logic [2:0] ch);
		logic [7:0] v;
		logic [7:0] r;
		v = 8'h13 + 8'h1d * {5'h00, ch};
		r = 8'h00;
		for (int b = 7; b >= 0; b--) if (v > (r | (8'h01 << b))) r = r | (8'h01 << b);
		return r;
	endfunction
	task automatic t_conv(input logic [2:0] ch, input logic [1:0] sel);
		xfer(32'h7c, 1'b1, {sel, ch, 3'h1});
		xfer(32'h7c, 1'b1, {sel, ch, 3'h5});
		xfer(32'h7c, 1'b0, 8'h00);
		chk({7'h00, rd_v[2]}, 8'h01);
		for (int i = 0; i < 150 && rd_v[2] !== 1'b0; i++) xfer(32'h7c, 1'b0, 8'h00);
		chk(rd_v, {sel, ch, 3'h1});
		xfer(32'h78, 1'b0, 8'h00);
		chk(rd_v, sar(ch));
	endtask
	task automatic t_regs;
		xfer(32'h7c, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		xfer(32'h30, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		xfer(32'h230, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		xfer(32'h200, 1'b0, 8'h00);
		chk({7'h00, err}, 8'h01);
		xfer(32'h7c, 1'b1, 8'h06);
		xfer(32'h7c, 1'b0, 8'h00);
		chk(rd_v, 8'h00);
		xfer(32'h27c, 1'b1, 8'h01);
		chk({7'h00, ref_ext}, 8'h01);
		chk(analog_pins, 8'hfe);
	endtask
	task automatic t_irq;
		xfer(32'h230, 1'b1, 8'h40);
		xfer(32'h30, 1'b0, 8'h00);
		t_conv(3'h1, 2'h0);
		@(negedge core_clk);
		chk({7'h00, irq}, 8'h01);
		xfer(32'h30, 1'b0, 8'h00);
		chk(rd_v, 8'h40);
		@(negedge core_clk);
		chk({7'h00, irq}, 8'h00);
		xfer(32'h230, 1'b1, 8'h00);
		t_conv(3'h2, 2'h0);
		@(negedge core_clk);
		chk({7'h00, irq}, 8'h00);
		xfer(32'h30, 1'b0, 8'h00);
		chk(rd_v, 8'h40);
	endtask
	task automatic t_abort;
		t_conv(3'h4, 2'h1);
		xfer(32'h7c, 1'b1, 8'h85);
		xfer(32'h7c, 1'b1, 8'h81);
		repeat (350) @(posedge core_clk);
		xfer(32'h78, 1'b0, 8'h00);
		chk(rd_v, sar(3'h4));
	endtask
	task automatic t_sleep;
		xfer(32'h230, 1'b1, 8'h40);
		xfer(32'h7c, 1'b1, 8'hd9);
		xfer(32'h7c, 1'b1, 8'hdd);
		cpu_sleep <= 1'b1;
		for (int i = 0; i < 400 && wake !== 1'b1; i++) @(posedge core_clk);
		chk({7'h00, wake}, 8'h01);
		cpu_sleep <= 1'b0;
		xfer(32'h78, 1'b0, 8'h00);
		chk(rd_v, sar(3'h3));
		xfer(32'h7c, 1'b1, 8'h21);
		xfer(32'h7c, 1'b1, 8'h25);
		cpu_sleep <= 1'b1;
		repeat (60) @(posedge core_clk);
		chk({7'h00, wake}, 8'h00);
		cpu_sleep <= 1'b0;
		xfer(32'h7c, 1'b0, 8'h00);
		chk(rd_v, 8'h21);
		xfer(32'h78, 1'b0, 8'h00);
		chk(rd_v, sar(3'h3));
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_regs();
		for (int c = 0; c < 8; c++) t_conv(c[2:0], c[1:0]);
		t_irq();
		t_abort();
		t_sleep();
		end_sim();
	end
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule
